// [orr_alu.sv]
// Purpose: Combinational result and write-steering for one operation.
// Assumes: Operands are stable for the whole take cycle.
// Notes:   No state here; the caller registers every result.
`timescale 1ns/100ps

module orr_alu
    import orr_pkg::*;
(
    input  wire orr_op_t    op,          // Operation being executed
    input  wire logic [7:0] accum,       // Current accumulator
    input  wire logic [7:0] imm,         // Immediate byte of the instruction
    input  wire logic [7:0] mem_byte,    // Addressed data memory byte
    output wire logic [7:0] result,      // Byte to be written
    output wire logic       to_accum,    // Result goes to the accumulator
    output wire logic       to_mem,      // Result goes back to memory
    output wire logic       set_zero     // Zero flag is updated from result
);

    wire logic [7:0] or_imm_val;
    wire logic [7:0] or_mem_val;
    wire logic [7:0] rot_val;

    assign or_imm_val = accum | imm;
    assign or_mem_val = accum | mem_byte;
    assign rot_val    = {mem_byte[MSB_BIT-1:0], mem_byte[MSB_BIT]};

    assign result = (op == OR_IMMEDIATE_OP)   ? or_imm_val :
                    (op == OR_INTO_MEMORY_OP) ? or_mem_val :
                    (op == RETURN_LOAD_OP)    ? imm        : rot_val;

    assign to_accum = (op == OR_IMMEDIATE_OP) || (op == RETURN_LOAD_OP)
                   || (op == ROTATE_LEFT_TO_ACCUMULATOR_OP);
    assign to_mem   = (op == OR_INTO_MEMORY_OP) || (op == ROTATE_LEFT_MEMORY_OP);
    // Rotates and returns leave every flag alone
    assign set_zero = (op == OR_IMMEDIATE_OP) || (op == OR_INTO_MEMORY_OP);

endmodule

// [orr_exec.sv]
// Purpose: Execution slice for OR, subroutine/interrupt returns and plain left rotates.
// Assumes: Decoder presents one operation with op_valid; memory address and stack top
//          are held stable by the core while op_valid is high.
// Notes:   Results appear in the cycle after the take cycle, all from flip-flops.
//          The hold-off after return from interrupt costs one fetch slot but lets
//          the core enter a waiting routine before the main program runs again.
`timescale 1ns/100ps

module orr_exec
    import orr_pkg::*;
(
    input  wire logic [0:0]  core_clk,               // 100 MHz core clock
    input  wire logic        nrst,                   // Asynchronous reset, active low
    input  wire logic        op_valid,               // Decoder offers an operation
    output wire logic        op_ready,               // Slice accepts an operation this cycle
    input  wire orr_op_t     op_code,                // Decoded operation
    input  wire logic [7:0]  op_imm,                 // Immediate byte of the instruction
    input  wire logic [7:0]  mem_rdata,              // Addressed data memory byte
    output logic             mem_wr,                 // Write strobe to data memory, one cycle
    output logic      [7:0]  mem_wdata,              // Data for mem_wr
    input  wire logic [10:0] stack_top,              // Return address on top of stack
    output wire logic        stack_pop,              // Pop request, in the take cycle
    output logic             pc_load,                // Load program counter, one cycle
    output logic      [10:0] pc_value,               // Address for pc_load
    input  wire logic        accum_wr,               // Other instructions write accumulator
    input  wire logic [7:0]  accum_wdata,            // Data for accum_wr
    output logic      [7:0]  accumulator,            // Accumulator contents
    output logic             zero_flag,              // Zero flag
    input  wire logic        irq_ctrl_wr,            // Software write of interrupt control
    input  wire logic [7:0]  irq_ctrl_wdata,         // Data for irq_ctrl_wr
    output logic      [7:0]  interrupt_control_reg,  // Interrupt control contents
    output wire logic        global_irq_enable,      // Bit 0 of interrupt control
    input  wire logic        irq_pending,            // Interrupt request waiting, same clock
    output logic             irq_service             // Enter interrupt routine, one cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic is_return(input orr_op_t op);
        is_return = (op == RETURN_OP) || (op == RETURN_LOAD_OP) || (op == RETURN_FROM_INTERRUPT_OP);
    endfunction

    orr_state_t state;
    orr_state_t next_state;

    wire logic        take;
    wire logic [7:0]  alu_result;
    wire logic        alu_to_accum;
    wire logic        alu_to_mem;
    wire logic        alu_set_zero;
    wire logic        ret_irq;
    wire logic        do_service;
    wire logic        slice_accum_wr;
    wire logic        slice_mem_wr;
    wire logic [7:0]  next_accumulator;
    wire logic        next_zero_flag;
    wire logic [7:0]  next_mem_wdata;
    wire logic [10:0] next_pc_value;
    wire logic [7:0]  next_sw_icr;
    wire logic        next_gie;
    wire logic [7:0]  next_icr;

    assign op_ready   = (state == ST_IDLE);
    assign take       = op_valid && op_ready && (op_code != NO_OP);
    assign stack_pop  = take && is_return(op_code);
    assign ret_irq    = take && (op_code == RETURN_FROM_INTERRUPT_OP);
    assign do_service = (state == ST_IRQ_CHECK) && irq_pending
                     && interrupt_control_reg[GIE_BIT];
    assign global_irq_enable = interrupt_control_reg[GIE_BIT];
    assign slice_accum_wr = take && alu_to_accum;
    assign slice_mem_wr   = take && alu_to_mem;

    orr_alu u_alu (
        .op       (op_code),
        .accum    (accumulator),
        .imm      (op_imm),
        .mem_byte (mem_rdata),
        .result   (alu_result),
        .to_accum (alu_to_accum),
        .to_mem   (alu_to_mem),
        .set_zero (alu_set_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing: after return from interrupt, hold off one cycle so a waiting
    // request is entered before the main program fetches again.

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ret_irq) begin
                    next_state = ST_IRQ_CHECK;
                end
            end
            ST_IRQ_CHECK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator and zero flag. An operation of this slice wins over a write
    // from the rest of the core in the same cycle.

    assign next_accumulator = slice_accum_wr ? alu_result :
                              accum_wr       ? accum_wdata : accumulator;
    assign next_zero_flag   = (alu_result == ZERO_BYTE);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accumulator <= ACCUM_RST;
        end else begin
            accumulator <= next_accumulator;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            zero_flag <= 1'b0;
        end else if (take && alu_set_zero) begin
            zero_flag <= next_zero_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory write-back. The data word holds after the strobe, so a reader
    // may look at it later than the strobe cycle.

    assign next_mem_wdata = slice_mem_wr ? alu_result : mem_wdata;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mem_wr <= 1'b0;
        end else begin
            mem_wr <= slice_mem_wr;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mem_wdata <= ZERO_BYTE;
        end else begin
            mem_wdata <= next_mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter reload from the stack. The stack top is read in the pop
    // cycle only; after that edge it no longer holds the return address.

    assign next_pc_value = stack_pop ? stack_top : pc_value;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc_load <= 1'b0;
        end else begin
            pc_load <= stack_pop;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc_value <= PC_RST;
        end else begin
            pc_value <= next_pc_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt control. The enable bit is set by a return from interrupt and
    // cleared on entry to a routine, both ahead of a software write in the same
    // cycle; the other bits follow software writes only.

    assign next_sw_icr = irq_ctrl_wr ? irq_ctrl_wdata : interrupt_control_reg;
    assign next_gie    = ret_irq    ? 1'b1 :
                         do_service ? 1'b0 : next_sw_icr[GIE_BIT];

    for (genvar gb = 0; gb < BYTE_W; gb++) begin : g_icr_bit
        if (gb == GIE_BIT) begin : g_enable
            assign next_icr[gb] = next_gie;
        end else begin : g_plain
            assign next_icr[gb] = next_sw_icr[gb];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_control_reg <= IRQ_CTRL_RST;
        end else begin
            interrupt_control_reg <= next_icr;
        end
    end

    // The service pulse is registered, so the core sees it in the cycle
    // after the hold-off, when fetching would otherwise resume.

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_service <= 1'b0;
        end else begin
            irq_service <= do_service;
        end
    end

endmodule

// [orr_exec_asserts.sv]
// Purpose: Concurrent checks on the execution slice ports.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Bound to every orr_exec instance.
`timescale 1ns/100ps

module orr_exec_asserts
    import orr_pkg::*;
(
    input wire logic [0:0]  core_clk,          // Clock
    input wire logic        nrst,              // Reset, active low
    input wire logic        op_valid,          // Offer
    input wire logic        op_ready,          // Accept
    input wire orr_op_t     op_code,           // Operation
    input wire logic [7:0]  op_imm,            // Immediate
    input wire logic [7:0]  mem_rdata,         // Memory byte
    input wire logic        mem_wr,            // Memory write
    input wire logic [7:0]  mem_wdata,         // Memory data
    input wire logic [10:0] stack_top,         // Stack top
    input wire logic        stack_pop,         // Pop
    input wire logic        pc_load,           // PC load
    input wire logic [10:0] pc_value,          // PC value
    input wire logic [7:0]  accumulator,       // Accumulator
    input wire logic        zero_flag,         // Zero flag
    input wire logic        global_irq_enable, // Global enable
    input wire logic        irq_pending,       // Request waiting
    input wire logic        irq_service        // Service pulse
);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic       take;
    logic [7:0] rot_m;
    assign take  = op_valid && op_ready && (op_code != NO_OP);
    assign rot_m = {mem_rdata[6:0], mem_rdata[7]};

    sequence s_take(orr_op_t c);
        take && (op_code == c);
    endsequence
    sequence s_rfi_pending;
        s_take(RETURN_FROM_INTERRUPT_OP) ##1 irq_pending;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_or_imm_result: assert property (s_take(OR_IMMEDIATE_OP) |=>
        accumulator == ($past(accumulator) | $past(op_imm)) && zero_flag == (accumulator == 8'h00))
        else $error("or immediate result wrong");
    a_or_mem_write: assert property (s_take(OR_INTO_MEMORY_OP) |=> mem_wr && $stable(accumulator) &&
        mem_wdata == ($past(accumulator) | $past(mem_rdata)) && zero_flag == (mem_wdata == 8'h00))
        else $error("or into memory result wrong");
    a_return_pc_load: assert property (take && op_code inside {RETURN_OP, RETURN_LOAD_OP,
        RETURN_FROM_INTERRUPT_OP} |-> stack_pop ##1 pc_load && pc_value == $past(stack_top) && $stable(zero_flag))
        else $error("return did not load pc");
    a_load_value: assert property (s_take(RETURN_LOAD_OP) |=> accumulator == $past(op_imm))
        else $error("return value not loaded");
    a_irq_enable_set: assert property (s_take(RETURN_FROM_INTERRUPT_OP) |=> global_irq_enable && !op_ready)
        else $error("global enable not set");
    a_pending_served: assert property (s_rfi_pending |=> irq_service)
        else $error("pending request not served");
    a_rotate_memory: assert property (s_take(ROTATE_LEFT_MEMORY_OP) |=>
        mem_wr && mem_wdata == $past(rot_m) && $stable(zero_flag))
        else $error("memory rotate wrong");
    a_rotate_accum: assert property (s_take(ROTATE_LEFT_TO_ACCUMULATOR_OP) |=>
        !mem_wr && accumulator == $past(rot_m) && $stable(zero_flag))
        else $error("accumulator rotate wrong");

endmodule

bind orr_exec orr_exec_asserts u_orr_exec_asserts (.core_clk, .nrst, .op_valid, .op_ready, .op_code, .op_imm,
    .mem_rdata, .mem_wr, .mem_wdata, .stack_top, .stack_pop, .pc_load, .pc_value, .accumulator, .zero_flag,
    .global_irq_enable, .irq_pending, .irq_service);

// [orr_pkg.sv]
// Purpose: Shared constants and types for the OR / return / rotate execution slice.
// Assumes: 8-bit data path, 11-bit program counter (2K word program space).
// Notes:   Operation codes are decoded upstream and handed over as orr_op_t.
package orr_pkg;

    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned PC_W      = 11;
    localparam int unsigned MSB_BIT   = 7;
    localparam int unsigned GIE_BIT   = 0;

    localparam logic [7:0]  ACCUM_RST = 8'h00;
    localparam logic [7:0]  IRQ_CTRL_RST = 8'h00;
    localparam logic [10:0] PC_RST    = 11'h000;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;

    typedef enum logic [2:0] {
        NO_OP,
        OR_IMMEDIATE_OP,
        OR_INTO_MEMORY_OP,
        RETURN_OP,
        RETURN_LOAD_OP,
        RETURN_FROM_INTERRUPT_OP,
        ROTATE_LEFT_MEMORY_OP,
        ROTATE_LEFT_TO_ACCUMULATOR_OP
    } orr_op_t;

    typedef enum {
        ST_IDLE,
        ST_IRQ_CHECK
    } orr_state_t;

endpackage

// [tb_top.sv]
// Purpose: Directed scenarios for the OR / return / rotate slice.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Outputs are looked at 1 ns after the edge that updates them.
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_top
    import orr_pkg::*;
;
    logic [0:0]  core_clk = 1'h0;
    logic        nrst = 1'h0, op_valid = 1'h0, accum_wr = 1'h0, irq_ctrl_wr = 1'h0, irq_pending = 1'h0;
    logic        last_pop = 1'h0;
    orr_op_t     op_code = NO_OP;
    logic [7:0]  op_imm = 8'h00, mem_rdata = 8'h00, accum_wdata = 8'h00, irq_ctrl_wdata = 8'h00;
    logic [10:0] stack_top = 11'h000;
    logic [7:0]  mem_wdata, accumulator, interrupt_control_reg;
    logic [10:0] pc_value;
    logic        op_ready, mem_wr, stack_pop, pc_load, zero_flag, global_irq_enable, irq_service;
    int          n_errors = 0, total_checks = 0;

    always #5 core_clk = ~core_clk;

    orr_exec u_orr_exec (.core_clk, .nrst, .op_valid, .op_ready, .op_code, .op_imm, .mem_rdata, .mem_wr,
        .mem_wdata, .stack_top, .stack_pop, .pc_load, .pc_value, .accum_wr, .accum_wdata, .accumulator,
        .zero_flag, .irq_ctrl_wr, .irq_ctrl_wdata, .interrupt_control_reg, .global_irq_enable, .irq_pending,
        .irq_service);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic go(orr_op_t c, logic [7:0] i, logic [7:0] m, logic [10:0] s);
        @(posedge core_clk);
        op_valid <= 1'h1;
        op_code <= c;
        op_imm <= i;
        mem_rdata <= m;
        stack_top <= s;
        #1;
        last_pop = stack_pop;
        @(posedge core_clk);
        op_valid <= 1'h0;
        #1;
    endtask

    task automatic load_accum(logic [7:0] v);
        @(posedge core_clk);
        accum_wr <= 1'h1;
        accum_wdata <= v;
        @(posedge core_clk);
        accum_wr <= 1'h0;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_or_ops();
        go(OR_IMMEDIATE_OP, 8'h00, 8'h00, 11'h000);
        `CHK(zero_flag, 1'h1)
        go(OR_IMMEDIATE_OP, 8'h5a, 8'h00, 11'h000);
        `CHK(accumulator, 8'h5a)
        load_accum(8'h24);
        go(OR_INTO_MEMORY_OP, 8'h00, 8'h81, 11'h000);
        `CHK({mem_wr, mem_wdata, accumulator, zero_flag}, {1'h1, 8'ha5, 8'h24, 1'h0})
    endtask

    task automatic t_returns();
        go(RETURN_OP, 8'h00, 8'h00, 11'h7ff);
        `CHK({pc_load, pc_value, zero_flag}, {1'h1, 11'h7ff, 1'h0})
        `CHK(last_pop, 1'h1)
        go(RETURN_LOAD_OP, 8'h00, 8'h00, 11'h123);
        `CHK({pc_value, accumulator, zero_flag}, {11'h123, 8'h00, 1'h0})
    endtask

    task automatic t_interrupt_return();
        @(posedge core_clk);
        irq_pending <= 1'h1;
        go(RETURN_FROM_INTERRUPT_OP, 8'h00, 8'h00, 11'h055);
        `CHK({pc_value, global_irq_enable, op_ready}, {11'h055, 1'h1, 1'h0})
        @(posedge core_clk);
        irq_pending <= 1'h0;
        #1;
        `CHK({irq_service, op_ready}, {1'h1, 1'h1})
        @(posedge core_clk);
        irq_ctrl_wr <= 1'h1;
        irq_ctrl_wdata <= 8'hf0;
        @(posedge core_clk);
        irq_ctrl_wr <= 1'h0;
        #1;
        `CHK(interrupt_control_reg, 8'hf0)
        go(RETURN_FROM_INTERRUPT_OP, 8'h00, 8'h00, 11'h066);
        @(posedge core_clk);
        #1;
        `CHK({irq_service, interrupt_control_reg, op_ready}, {1'h0, 8'hf1, 1'h1})
    endtask

    task automatic t_rotates();
        go(OR_IMMEDIATE_OP, 8'h00, 8'h00, 11'h000);
        `CHK({accumulator, zero_flag}, {8'h00, 1'h1})
        go(ROTATE_LEFT_MEMORY_OP, 8'h00, 8'h81, 11'h000);
        `CHK({mem_wr, mem_wdata, zero_flag}, {1'h1, 8'h03, 1'h1})
        go(ROTATE_LEFT_TO_ACCUMULATOR_OP, 8'h00, 8'h80, 11'h000);
        `CHK({mem_wr, accumulator, zero_flag}, {1'h0, 8'h01, 1'h1})
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'h1;
        #1;
        `CHK({accumulator, interrupt_control_reg}, {ACCUM_RST, IRQ_CTRL_RST})
        t_or_ops();
        t_returns();
        t_interrupt_return();
        t_rotates();
        complete_run();
    end

    // The scenarios need well under a hundred cycles
    initial begin
        repeat (500) @(posedge core_clk);
        n_errors++;
        complete_run();
    end
endmodule
